// ---- core/fss_pkg.sv ----
package fss_pkg;

    // ****************************************************************
    // forced-stop method codes
    // ****************************************************************
    localparam logic [3:0] METHOD_DB_COAST = 4'h0;
    localparam logic [3:0] METHOD_TRQ_PRESET = 4'h1;
    localparam logic [3:0] METHOD_TRQ_COAST = 4'h2;
    localparam logic [3:0] METHOD_RAMP_PRESET = 4'h3;
    localparam logic [3:0] METHOD_RAMP_COAST = 4'h4;
    localparam logic [3:0] METHOD_RESET = 4'h1;

    // ****************************************************************
    // servo-off stopping method codes (post-stop state)
    // ****************************************************************
    localparam logic [1:0] SOFF_DB_HOLD = 2'h0;
    localparam logic [1:0] SOFF_DB_RELEASE = 2'h1;
    localparam logic [1:0] SOFF_COAST = 2'h2;

    // ****************************************************************
    // setting ranges and reset values
    // ****************************************************************
    localparam logic [9:0] TORQUE_LIMIT_MAX = 10'h320;
    localparam logic [9:0] TORQUE_LIMIT_RESET = 10'h320;
    localparam logic [13:0] DECEL_TIME_MAX = 14'h2710;
    localparam logic [13:0] DECEL_TIME_RESET = 14'h0000;

    // ****************************************************************
    // timing: one decel-time unit is 1 ms
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int DECEL_UNIT_NS = 1000000;
    localparam int MS_CYCLES = DECEL_UNIT_NS / CLK_PERIOD_NS;

    // ****************************************************************
    // sequencer states
    // ****************************************************************
    typedef enum logic [4:0] {
        FSS_RUN = 5'h01,
        FSS_TRQ_DECEL = 5'h02,
        FSS_RAMP_DECEL = 5'h04,
        FSS_POST_STOP = 5'h08,
        FSS_BLOCKED = 5'h10
    } fss_state_e;

endpackage : fss_pkg

// ---- core/fss_ms_tick.sv ----
`timescale 1ns/1ps

// ****************************************************************
// millisecond enable divider
// ****************************************************************
module fss_ms_tick #(
    parameter int CYCLES = fss_pkg::MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic tick_o
);

    // the divider counter is 20 bits wide
    if (CYCLES < 2 || CYCLES > 1048576)
    begin : g_bad_cycles
        $error("fss_ms_tick: CYCLES out of range");
    end

    logic [19:0] cnt_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= 20'h00000;
            tick_o <= 1'b0;
        end
        else if (cnt_q == 20'(CYCLES - 1))
        begin
            cnt_q <= 20'h00000;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 20'h00001;
            tick_o <= 1'b0;
        end
    end

endmodule : fss_ms_tick

// ---- core/fss_sequencer.sv ----
`timescale 1ns/1ps

// Contract
// - method 0 stops by dynamic brake or coast per servo-off stop method.
// - method 1 torque-limited decel, then post-stop state per servo-off method.
// - method 2 torque-limited decel, then coast.
// - method 3 ramp over decel time, then post-stop per servo-off method.
// - method 4 ramp over decel time, then coast.
// - in torque control no controlled decel; brake or coast instead.
// - emergency torque limit 0 to 800 percent, default 800.
// - applied emergency torque never exceeds motor maximum torque.
// - decel time 0 to 10000 ms, default 0, effective immediately.
// - decel time zero commands zero speed at once.
// - ramp slope scaled so set time covers maximum speed to zero.
// - servo-on during inactive stop input keeps stop latched.
module fss_sequencer #(
    parameter int SPEED_W = 16,
    parameter int TORQUE_W = 10,
    parameter int MS_CYCLES = fss_pkg::MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic forced_stop_input_i,
    input wire logic servo_on_command_i,
    input wire logic servo_off_command_i,
    input wire logic torque_mode_i,
    input wire logic [3:0] forced_stop_method_select_i,
    input wire logic [1:0] servo_off_stop_method_i,
    input wire logic [9:0] emergency_stop_torque_limit_i,
    input wire logic [13:0] forced_stop_decel_time_i,
    input wire logic [SPEED_W-1:0] speed_i,
    input wire logic [SPEED_W-1:0] max_speed_i,
    input wire logic [TORQUE_W-1:0] motor_max_torque_i,
    output logic forced_stop_active_o,
    output logic power_stage_blocked_state_o,
    output logic dyn_brake_o,
    output logic torque_limit_en_o,
    output logic [TORQUE_W-1:0] torque_limit_o,
    output logic speed_ref_en_o,
    output logic [SPEED_W-1:0] speed_ref_o
);

    // torque cap must hold 800 percent, so at least 10 bits
    if (SPEED_W < 4 || SPEED_W > 32 || TORQUE_W < 10 || TORQUE_W > 16)
    begin : g_bad_width
        $error("fss_sequencer: width parameter out of range");
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [13:0] clip_time(input logic [13:0] t);
        clip_time = (t > fss_pkg::DECEL_TIME_MAX) ? fss_pkg::DECEL_TIME_MAX : t;
    endfunction : clip_time

    function automatic logic is_coast_code(input logic [3:0] m);
        is_coast_code = (m == fss_pkg::METHOD_TRQ_COAST) || (m == fss_pkg::METHOD_RAMP_COAST);
    endfunction : is_coast_code

    fss_pkg::fss_state_e state_q;
    logic stop_in_q;
    logic latched_q;
    logic post_coast_q;
    logic [SPEED_W-1:0] ref_q;
    logic [TORQUE_W-1:0] tlim_q;
    logic [SPEED_W+13:0] acc_q;
    logic ms_tick;
    logic stop_fall;
    logic ramp_ok;
    logic [SPEED_W-1:0] ramp_step;
    logic [13:0] eff_time;
    logic [TORQUE_W-1:0] trq_req;

    fss_ms_tick #(
        .CYCLES(MS_CYCLES)
    ) u_tick (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_o(ms_tick)
    );

    // inactive level is low; start on falling edge
    assign stop_fall = stop_in_q && !forced_stop_input_i;
    // time read live every cycle, clipped to its range
    assign eff_time = clip_time(forced_stop_decel_time_i);
    // torque control never takes the controlled paths
    assign ramp_ok = !torque_mode_i;

    // ****************************************************************
    // torque cap
    // ****************************************************************
    always_comb
    begin
        // setting clipped to 800 percent of rated
        trq_req = (emergency_stop_torque_limit_i > fss_pkg::TORQUE_LIMIT_MAX) ?
            TORQUE_W'(fss_pkg::TORQUE_LIMIT_MAX) : TORQUE_W'(emergency_stop_torque_limit_i);
        if (trq_req > motor_max_torque_i)
        begin
            trq_req = motor_max_torque_i;
        end
    end

    // ****************************************************************
    // ramp step: max speed per decel time, fractional accumulator
    // ****************************************************************
    logic [SPEED_W+13:0] acc_sum;
    // per-ms step = max_speed / time, with carried remainder
    assign acc_sum = acc_q + (SPEED_W+14)'(max_speed_i);
    always_comb
    begin
        ramp_step = '0;
        if (eff_time != 14'h0000)
        begin
            ramp_step = SPEED_W'(acc_sum / (SPEED_W+14)'(eff_time));
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            stop_in_q <= 1'b1;
        end
        else
        begin
            stop_in_q <= forced_stop_input_i;
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= fss_pkg::FSS_RUN;
            post_coast_q <= 1'b0;
            ref_q <= '0;
            acc_q <= '0;
            tlim_q <= TORQUE_W'(fss_pkg::TORQUE_LIMIT_RESET);
        end
        else
        begin
            tlim_q <= trq_req;
            case (state_q)
                fss_pkg::FSS_RUN:
                begin
                    if (stop_fall)
                    begin
                        post_coast_q <= is_coast_code(forced_stop_method_select_i);
                        ref_q <= speed_i;
                        acc_q <= '0;
                        case (forced_stop_method_select_i)
                            fss_pkg::METHOD_TRQ_PRESET, fss_pkg::METHOD_TRQ_COAST:
                                state_q <= ramp_ok ? fss_pkg::FSS_TRQ_DECEL
                                                   : fss_pkg::FSS_POST_STOP;
                            fss_pkg::METHOD_RAMP_PRESET, fss_pkg::METHOD_RAMP_COAST:
                                state_q <= ramp_ok ? fss_pkg::FSS_RAMP_DECEL
                                                   : fss_pkg::FSS_POST_STOP;
                            default:
                                state_q <= fss_pkg::FSS_POST_STOP;
                        endcase
                        if (!ramp_ok || forced_stop_method_select_i == fss_pkg::METHOD_DB_COAST)
                        begin
                            post_coast_q <= 1'b0;
                        end
                    end
                end
                fss_pkg::FSS_TRQ_DECEL:
                begin
                    // zero speed ref, loop saturates at the torque cap
                    ref_q <= '0;
                    if (speed_i == '0)
                    begin
                        state_q <= fss_pkg::FSS_POST_STOP;
                    end
                end
                fss_pkg::FSS_RAMP_DECEL:
                begin
                    if (eff_time == 14'h0000)
                    begin
                        ref_q <= '0;
                        state_q <= fss_pkg::FSS_POST_STOP;
                    end
                    else if (ms_tick)
                    begin
                        // slope max speed over set time
                        acc_q <= acc_sum - (SPEED_W+14)'(ramp_step) * (SPEED_W+14)'(eff_time);
                        if (ref_q <= ramp_step)
                        begin
                            ref_q <= '0;
                            state_q <= fss_pkg::FSS_POST_STOP;
                        end
                        else
                        begin
                            ref_q <= ref_q - ramp_step;
                        end
                    end
                end
                fss_pkg::FSS_POST_STOP:
                begin
                    ref_q <= '0;
                    if (servo_off_command_i)
                    begin
                        state_q <= fss_pkg::FSS_BLOCKED;
                    end
                end
                fss_pkg::FSS_BLOCKED:
                begin
                    // resume only if input back and servo-on
                    if (servo_on_command_i && forced_stop_input_i && !latched_q)
                    begin
                        state_q <= fss_pkg::FSS_RUN;
                    end
                end
                default:
                    state_q <= fss_pkg::FSS_POST_STOP;
            endcase
        end
    end

    // ****************************************************************
    // latch: servo-on while stop input inactive poisons recovery
    // ****************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            latched_q <= 1'b0;
        end
        // latch set wins over the clearing servo-off
        else if (servo_on_command_i && !forced_stop_input_i && state_q != fss_pkg::FSS_RUN)
        begin
            latched_q <= 1'b1;
        end
        else if (servo_off_command_i)
        begin
            latched_q <= 1'b0;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    logic blocked;
    assign blocked = (state_q == fss_pkg::FSS_POST_STOP) || (state_q == fss_pkg::FSS_BLOCKED);
    assign forced_stop_active_o = state_q != fss_pkg::FSS_RUN;
    assign power_stage_blocked_state_o = blocked;
    // brake while stopped unless coast chosen by method or servo-off setting; DB release frees it in the blocked state
    assign dyn_brake_o = blocked && !post_coast_q &&
        (servo_off_stop_method_i != fss_pkg::SOFF_COAST) &&
        !(state_q == fss_pkg::FSS_BLOCKED && servo_off_stop_method_i == fss_pkg::SOFF_DB_RELEASE);
    // torque cap only during torque decel
    assign torque_limit_en_o = state_q == fss_pkg::FSS_TRQ_DECEL;
    assign torque_limit_o = tlim_q;
    assign speed_ref_en_o = (state_q == fss_pkg::FSS_TRQ_DECEL) ||
        (state_q == fss_pkg::FSS_RAMP_DECEL);
    assign speed_ref_o = ref_q;

endmodule : fss_sequencer

// ---- bench/fss_sequencer_chk.sv ----
`timescale 1ns/1ps
module fss_sequencer_chk #(
    parameter int SPEED_W = 16,
    parameter int TORQUE_W = 10,
    parameter int MS_CYCLES = 10
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic forced_stop_input_i,
    input wire logic servo_on_command_i,
    input wire logic servo_off_command_i,
    input wire logic torque_mode_i,
    input wire logic [3:0] forced_stop_method_select_i,
    input wire logic [1:0] servo_off_stop_method_i,
    input wire logic [9:0] emergency_stop_torque_limit_i,
    input wire logic [13:0] forced_stop_decel_time_i,
    input wire logic [SPEED_W-1:0] speed_i,
    input wire logic [TORQUE_W-1:0] motor_max_torque_i,
    input wire logic forced_stop_active_o,
    input wire logic power_stage_blocked_state_o,
    input wire logic dyn_brake_o,
    input wire logic torque_limit_en_o,
    input wire logic [TORQUE_W-1:0] torque_limit_o,
    input wire logic speed_ref_en_o,
    input wire logic [SPEED_W-1:0] speed_ref_o
);
    // ****************************************************************
    // expected torque cap and latch shadow
    // ****************************************************************
    logic [TORQUE_W-1:0] cap;
    logic latch_q;
    logic coast_q;
    // coast choice frozen at the stop edge; torque control falls back to servo-off method
    always_ff @(posedge clk_i)
    begin
        if (!forced_stop_active_o)
        begin
            coast_q <= !torque_mode_i && (forced_stop_method_select_i == 4'h2
                || forced_stop_method_select_i == 4'h4);
        end
    end
    always_comb
    begin
        cap = TORQUE_W'(emergency_stop_torque_limit_i);
        if (emergency_stop_torque_limit_i > fss_pkg::TORQUE_LIMIT_MAX)
            cap = TORQUE_W'(fss_pkg::TORQUE_LIMIT_MAX);
        if (motor_max_torque_i < cap)
            cap = motor_max_torque_i;
    end
    // set wins over clear, as in the design
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            latch_q <= 1'h0;
        else if (forced_stop_active_o && servo_on_command_i && !forced_stop_input_i)
            latch_q <= 1'h1;
        else if (servo_off_command_i)
            latch_q <= 1'h0;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    stop_start_a: assert property (
        !forced_stop_active_o && $past(forced_stop_input_i) && !forced_stop_input_i
        |=> forced_stop_active_o) else $error("stop request not taken");
    imm_stop_a: assert property (
        $rose(forced_stop_active_o) && ($past(torque_mode_i)
        || $past(forced_stop_method_select_i) == 4'h0)
        |-> !speed_ref_en_o && !torque_limit_en_o ##1 power_stage_blocked_state_o
        && !speed_ref_en_o && !torque_limit_en_o) else $error("controlled decel not skipped");
    trq_cap_a: assert property (
        1'h1 |=> torque_limit_o == $past(cap)) else $error("torque cap wrong");
    trq_hold_a: assert property (
        torque_limit_en_o && speed_i != 0 |=> torque_limit_en_o && speed_ref_o == 0)
        else $error("torque decel left early");
    trq_end_a: assert property (
        torque_limit_en_o && speed_i == 0 |=> ##[0:1] power_stage_blocked_state_o)
        else $error("torque decel did not end");
    ramp_load_a: assert property (
        $rose(speed_ref_en_o) |-> speed_ref_o == $past(speed_i))
        else $error("ramp start value wrong");
    ramp_zero_a: assert property (
        $rose(speed_ref_en_o) && !torque_limit_en_o && forced_stop_decel_time_i == 14'h0000
        |=> ##[0:1] power_stage_blocked_state_o) else $error("zero time not immediate");
    coast_a: assert property (
        power_stage_blocked_state_o && (coast_q
        || servo_off_stop_method_i == fss_pkg::SOFF_COAST) |-> !dyn_brake_o)
        else $error("brake on while coasting");
    latch_hold_a: assert property (
        latch_q && forced_stop_active_o |=> forced_stop_active_o)
        else $error("latched stop released");
    rearm_a: assert property (
        $fell(forced_stop_active_o) |-> $past(servo_on_command_i) && $past(forced_stop_input_i))
        else $error("run resumed without servo-on");
endmodule : fss_sequencer_chk

bind fss_sequencer fss_sequencer_chk #(
    .SPEED_W(SPEED_W),
    .TORQUE_W(TORQUE_W),
    .MS_CYCLES(MS_CYCLES)
) u_chk (.*);

// ---- bench/fss_host_model.sv ----
`timescale 1ns/1ps
module fss_host_model (
    input wire logic clk_i,
    output logic servo_on_command_o,
    output logic servo_off_command_o
);
    initial
    begin
        servo_on_command_o = 1'h0;
        servo_off_command_o = 1'h0;
    end
    // one-cycle command pulse, launched just after an edge
    task automatic pulse(input bit on);
        @(posedge clk_i);
        #1;
        if (on) servo_on_command_o = 1'h1; else servo_off_command_o = 1'h1;
        @(posedge clk_i);
        #1;
        servo_on_command_o = 1'h0;
        servo_off_command_o = 1'h0;
    endtask : pulse
    task automatic clear_stop();
        pulse(1'b0);
        repeat (2) @(posedge clk_i);
        pulse(1'b1);
    endtask : clear_stop
endmodule : fss_host_model

// ---- bench/fss_sequencer_bench.sv ----
`timescale 1ns/1ps
module fss_sequencer_bench;
    logic clk_i, rst_n_i, forced_stop_input_i, servo_on_command_i, servo_off_command_i;
    logic torque_mode_i, forced_stop_active_o, power_stage_blocked_state_o, dyn_brake_o;
    logic torque_limit_en_o, speed_ref_en_o;
    logic [3:0] forced_stop_method_select_i;
    logic [1:0] servo_off_stop_method_i;
    logic [9:0] emergency_stop_torque_limit_i, motor_max_torque_i, torque_limit_o;
    logic [13:0] forced_stop_decel_time_i;
    logic [15:0] speed_i, max_speed_i, speed_ref_o;
    int miscompares, compares, n;
    // short millisecond so ramps finish in tens of cycles
    fss_sequencer #(.MS_CYCLES(10)) dut (.*);
    fss_host_model host (.clk_i(clk_i), .servo_on_command_o(servo_on_command_i),
        .servo_off_command_o(servo_off_command_i));
    always #5 clk_i = ~clk_i;
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic give_verdict();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // blk: wait for blocked, else wait for run
    task automatic wait_for(input bit blk, input int lim);
        n = 0;
        while ((blk ? power_stage_blocked_state_o !== 1'h1 : forced_stop_active_o !== 1'h0)
            && n < lim)
        begin
            cyc(1);
            n++;
        end
        if (n >= lim)
        begin
            miscompares++;
            $display("FAIL t=%0t waited=%h limit=%h", $time, n, lim);
            give_verdict();
        end
    endtask : wait_for
    task automatic recover();
        forced_stop_input_i = 1'h1;
        host.clear_stop();
        wait_for(1'b0, 4);
    endtask : recover
    task automatic sc_immediate();
        servo_off_stop_method_i = fss_pkg::SOFF_DB_HOLD;
        forced_stop_method_select_i = fss_pkg::METHOD_DB_COAST;
        forced_stop_input_i = 1'h0;
        wait_for(1'b1, 4);
        chk(speed_ref_en_o | torque_limit_en_o, 16'h0000);
        chk(dyn_brake_o, 16'h0001);
        recover();
        torque_mode_i = 1'h1;
        servo_off_stop_method_i = fss_pkg::SOFF_COAST;
        forced_stop_method_select_i = fss_pkg::METHOD_RAMP_PRESET;
        forced_stop_input_i = 1'h0;
        wait_for(1'b1, 4);
        chk(speed_ref_en_o | torque_limit_en_o | dyn_brake_o, 16'h0000);
        recover();
        torque_mode_i = 1'h0;
        $display("immediate stop test done");
    endtask : sc_immediate
    task automatic sc_torque();
        servo_off_stop_method_i = fss_pkg::SOFF_DB_HOLD;
        emergency_stop_torque_limit_i = 10'h3E7;
        for (int m = 1; m <= 2; m++)
        begin
            motor_max_torque_i = (m == 1) ? 10'h3FF : 10'h12C;
            forced_stop_method_select_i = 4'(m);
            forced_stop_input_i = 1'h0;
            cyc(20);
            chk(torque_limit_en_o, 16'h0001);
            chk(torque_limit_o, (m == 1) ? 16'h0320 : 16'h012C);
            chk(power_stage_blocked_state_o, 16'h0000);
            speed_i = 16'h0000;
            wait_for(1'b1, 4);
            chk(dyn_brake_o, (m == 1) ? 16'h0001 : 16'h0000);
            speed_i = 16'h0100;
            recover();
        end
        $display("torque decel test done");
    endtask : sc_torque
    task automatic sc_ramp();
        speed_i = 16'h03E8;
        forced_stop_decel_time_i = 14'h0005;
        forced_stop_method_select_i = fss_pkg::METHOD_RAMP_PRESET;
        forced_stop_input_i = 1'h0;
        cyc(1);
        chk(speed_ref_o, 16'h03E8);
        wait_for(1'b1, 90);
        chk(16'(n >= 35 && n <= 62), 16'h0001);
        chk(dyn_brake_o, 16'h0001);
        recover();
        forced_stop_decel_time_i = 14'h0000;
        forced_stop_method_select_i = fss_pkg::METHOD_RAMP_COAST;
        forced_stop_input_i = 1'h0;
        wait_for(1'b1, 5);
        chk(dyn_brake_o, 16'h0000);
        recover();
        speed_i = 16'h0100;
        $display("ramp test done");
    endtask : sc_ramp
    task automatic sc_latch();
        forced_stop_method_select_i = fss_pkg::METHOD_DB_COAST;
        forced_stop_input_i = 1'h0;
        wait_for(1'b1, 4);
        // go to the blocked state first, so only the latch can hold the stop
        host.pulse(1'b0);
        host.pulse(1'b1);
        forced_stop_input_i = 1'h1;
        cyc(2);
        host.pulse(1'b1);
        cyc(4);
        chk(forced_stop_active_o, 16'h0001);
        recover();
        chk(forced_stop_active_o, 16'h0000);
        $display("latch test done");
    endtask : sc_latch
    initial
    begin
        clk_i = 1'h0;
        rst_n_i = 1'h0;
        forced_stop_input_i = 1'h1;
        torque_mode_i = 1'h0;
        forced_stop_method_select_i = 4'h0;
        servo_off_stop_method_i = 2'h0;
        emergency_stop_torque_limit_i = 10'h320;
        forced_stop_decel_time_i = 14'h0000;
        speed_i = 16'h0100;
        max_speed_i = 16'h03E8;
        motor_max_torque_i = 10'h3FF;
        miscompares = 0;
        compares = 0;
        cyc(16);
        chk(torque_limit_o, 16'h0320);
        rst_n_i = 1'h1;
        cyc(2);
        sc_immediate();
        sc_torque();
        sc_ramp();
        sc_latch();
        give_verdict();
    end
endmodule : fss_sequencer_bench
